// File: hw/usb_dev_ctrl_pkg.sv
// constants for the usb device state control block
package usb_dev_ctrl_pkg;
  localparam int NUM_EP           = 8;
  localparam int EP_IDX_W         = 3;
  localparam int SIZE_W           = 3;
  localparam int BANK_W           = 2;
  localparam int ADDR_W           = 7;
  localparam int BUF_W            = 16;
  localparam int CLK_MHZ          = 250;
  localparam int SUSPEND_IDLE_MS  = 3;
  localparam int SUSPEND_CYCLES   = SUSPEND_IDLE_MS * 1000 * CLK_MHZ;
  localparam logic [BUF_W-1:0] RAM_BYTES        = 16'h1000;
  localparam logic [BUF_W-1:0] EP0_MAX_BYTES    = 16'h0040;
  localparam logic [BUF_W-1:0] EPN_MAX_BYTES    = 16'h0400;
  localparam logic [BANK_W-1:0] EP0_MAX_BANKS   = 2'h1;
  localparam logic [BANK_W-1:0] EPN_MAX_BANKS   = 2'h3;
  localparam logic [ADDR_W-1:0] DEFAULT_ADDR    = 7'h00;
  localparam logic             DETACH_RST       = 1'b1;
  localparam logic             FREEZE_RST       = 1'b1;
  localparam logic             PIN_SEL_RST      = 1'b1;
  localparam logic             SW_ROLE_RST      = 1'b1;
  localparam logic [1:0]       SPEED_FULL       = 2'h0;
  localparam logic [1:0]       SPEED_HIGH       = 2'h1;
  localparam logic [1:0]       SPEED_LOW        = 2'h2;
  typedef enum logic [1:0] {DEV_RESET, DEV_IDLE, DEV_RUN} dev_state_t;
endpackage

// File: hw/ep_window_table.sv
// per-endpoint buffer window table, registered read
`timescale 1ns/10ps
module ep_window_table #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int DW    = 32
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// File: hw/usb_device_state_control.sv
// device-side state core of the usb controller
`timescale 1ns/10ps
module usb_device_state_control
  import usb_dev_ctrl_pkg::*;
#(
  parameter int SUSPEND_COUNT = usb_dev_ctrl_pkg::SUSPEND_CYCLES
) (
  // clock and reset
  input  wire logic                                       clk,
  input  wire logic                                       srst,
  // software control
  input  wire logic                                       ctrl_enable,
  input  wire logic                                       detach_set,
  input  wire logic                                       detach_clr,
  input  wire logic                                       freeze_set,
  input  wire logic                                       freeze_clr,
  input  wire logic                                       role_pin_select,
  input  wire logic                                       software_role_bit,
  input  wire logic                                       flag_clr_vbus,
  input  wire logic                                       flag_clr_id,
  input  wire logic                                       flag_clr_end_of_bus_reset_flag,
  input  wire logic                                       flag_clr_suspend_flag,
  input  wire logic                                       flag_clr_wake,
  // address setup
  input  wire logic                                       addr_wr,
  input  wire logic [usb_dev_ctrl_pkg::ADDR_W-1:0]        addr_wdata,
  input  wire logic                                       addr_en_wdata,
  // endpoint configuration write
  input  wire logic                                       ep_cfg_wr,
  input  wire logic [usb_dev_ctrl_pkg::EP_IDX_W-1:0]      ep_cfg_idx,
  input  wire logic [usb_dev_ctrl_pkg::SIZE_W-1:0]        ep_size_code,
  input  wire logic [usb_dev_ctrl_pkg::BANK_W-1:0]        ep_bank_count,
  input  wire logic                                       ep_allocate_bit,
  input  wire logic [usb_dev_ctrl_pkg::NUM_EP-1:0]        endpoint_enable_bit,
  input  wire logic [usb_dev_ctrl_pkg::NUM_EP-1:0]        endpoint_reset_bit,
  input  wire logic [usb_dev_ctrl_pkg::NUM_EP-1:0]        toggle_reset_set_bit,
  input  wire logic [usb_dev_ctrl_pkg::NUM_EP-1:0]        ep_toggle_flip,
  // bus line events from the serial engine
  input  wire logic                                       line_idle,
  input  wire logic                                       line_bus_reset,
  input  wire logic                                       host_hs_capable,
  input  wire logic                                       low_speed_sel,
  input  wire logic                                       token_valid,
  input  wire logic [usb_dev_ctrl_pkg::ADDR_W-1:0]        token_addr,
  input  wire logic [usb_dev_ctrl_pkg::EP_IDX_W-1:0]      token_ep,
  // analog comparators and id pin
  input  wire logic                                       session_valid,
  input  wire logic                                       bus_level_ok,
  input  wire logic                                       role_id_pin,
  // status
  output logic                                            bus_voltage_status,
  output logic                                            role_id_status,
  output logic                                            bus_voltage_change_flag,
  output logic                                            role_pin_change_flag,
  output logic                                            suspend_flag,
  output logic                                            wake_flag,
  output logic                                            end_of_bus_reset_flag,
  output logic [1:0]                                      speed_status,
  output logic                                            usb_clock_freeze,
  output logic                                            device_active,
  output logic [usb_dev_ctrl_pkg::ADDR_W-1:0]             device_address_field,
  output logic                                            address_enable,
  output logic                                            token_accept,
  output logic [usb_dev_ctrl_pkg::NUM_EP-1:0]             config_ok_flag,
  output logic [usb_dev_ctrl_pkg::NUM_EP-1:0]             ep_active,
  output logic [usb_dev_ctrl_pkg::NUM_EP-1:0]             toggle_sequence_field,
  output logic [usb_dev_ctrl_pkg::BUF_W-1:0]              ep_win_base,
  // pad
  output logic                                            pad_rx_enable,
  output logic                                            pad_pulldown_enable,
  output logic                                            pullup_dp,
  output logic                                            pullup_dm
);
  import usb_dev_ctrl_pkg::*;

  function automatic logic [BUF_W-1:0] ep_bytes(input logic [SIZE_W-1:0] code);
    ep_bytes = BUF_W'(16'h0008 << code);
  endfunction

  function automatic logic [BUF_W-1:0] window_bytes(input logic [SIZE_W-1:0] code,
                                                    input logic [BANK_W-1:0] banks);
    window_bytes = BUF_W'(ep_bytes(code) * banks);
  endfunction

  // three-stage synchronisers
  logic [2:0] sess_sync_reg, bvalid_sync_reg, id_sync_reg;
  always_ff @(posedge clk) begin
    sess_sync_reg   <= {sess_sync_reg[1:0], session_valid};
    bvalid_sync_reg <= {bvalid_sync_reg[1:0], bus_level_ok};
    id_sync_reg     <= {id_sync_reg[1:0], role_id_pin};
  end

  // stage 2 and 3 must agree; keeps a glitch from making two flags
  logic sess_ok_reg, bvalid_ok_reg, id_ok_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      sess_ok_reg   <= 1'b0;
      bvalid_ok_reg <= 1'b0;
      id_ok_reg     <= 1'b1;
    end else begin
      if (sess_sync_reg[1] == sess_sync_reg[2])     sess_ok_reg   <= sess_sync_reg[2];
      if (bvalid_sync_reg[1] == bvalid_sync_reg[2]) bvalid_ok_reg <= bvalid_sync_reg[2];
      if (id_sync_reg[1] == id_sync_reg[2])         id_ok_reg     <= id_sync_reg[2];
    end
  end

  // role and bus voltage status, live whether enabled or not
  logic role_next, vbus_next;
  always_comb begin
    role_next = role_pin_select ? id_ok_reg : software_role_bit;
    if (role_id_status) begin
      vbus_next = sess_ok_reg;
    end else if (bvalid_ok_reg) begin
      vbus_next = 1'b1;
    end else if (!sess_ok_reg) begin
      vbus_next = 1'b0;
    end else begin
      vbus_next = bus_voltage_status;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      role_id_status          <= SW_ROLE_RST;
      bus_voltage_status      <= 1'b0;
      role_pin_change_flag    <= 1'b0;
      bus_voltage_change_flag <= 1'b0;
    end else begin
      role_id_status     <= role_next;
      bus_voltage_status <= vbus_next;
      // set wins over clear
      if (role_next != role_id_status) role_pin_change_flag <= 1'b1;
      else if (flag_clr_id)            role_pin_change_flag <= 1'b0;
      if (vbus_next != bus_voltage_status) bus_voltage_change_flag <= 1'b1;
      else if (flag_clr_vbus)              bus_voltage_change_flag <= 1'b0;
    end
  end

  // device mode state
  logic       detach_reg;
  dev_state_t state_reg;
  logic       dev_on;
  assign dev_on = ctrl_enable && role_id_status;
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DEV_RESET;
    end else begin
      case (state_reg)
        DEV_RESET: if (dev_on) state_reg <= DEV_IDLE;
        DEV_IDLE:  if (!dev_on) state_reg <= DEV_RESET;
                   else if (!detach_reg && bus_voltage_status) state_reg <= DEV_RUN;
        DEV_RUN:   if (!dev_on) state_reg <= DEV_RESET;
                   else if (detach_reg) state_reg <= DEV_IDLE;
        default:   state_reg <= DEV_RESET;
      endcase
    end
  end

  // detach and clock freeze controls
  always_ff @(posedge clk) begin
    if (srst) begin
      detach_reg       <= DETACH_RST;
      usb_clock_freeze <= FREEZE_RST;
    end else begin
      if (detach_set)      detach_reg <= 1'b1;
      else if (detach_clr) detach_reg <= 1'b0;
      if (freeze_set)      usb_clock_freeze <= 1'b1;
      else if (freeze_clr) usb_clock_freeze <= 1'b0;
    end
  end

  logic dev_reset;
  assign dev_reset = (state_reg == DEV_RESET);

  // bus reset tracking and speed choice
  logic bus_reset_d_reg;
  always_ff @(posedge clk) begin
    if (srst || dev_reset) begin
      bus_reset_d_reg       <= 1'b0;
      end_of_bus_reset_flag <= 1'b0;
      speed_status          <= SPEED_FULL;
    end else begin
      bus_reset_d_reg <= line_bus_reset;
      if (line_bus_reset) begin
        speed_status <= low_speed_sel ? SPEED_LOW : (host_hs_capable ? SPEED_HIGH : SPEED_FULL);
      end
      if (bus_reset_d_reg && !line_bus_reset) end_of_bus_reset_flag <= 1'b1;
      else if (flag_clr_end_of_bus_reset_flag)                end_of_bus_reset_flag <= 1'b0;
    end
  end

  // idle timer and suspend / wake flags
  logic [$clog2(SUSPEND_COUNT+1)-1:0] idle_cnt_reg;
  logic                               suspend_flag_hit;
  assign suspend_flag_hit = (state_reg == DEV_RUN) && line_idle && !suspend_flag &&
                    (idle_cnt_reg == ($bits(idle_cnt_reg))'(SUSPEND_COUNT - 1));
  always_ff @(posedge clk) begin
    if (srst || !line_idle || state_reg != DEV_RUN) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != ($bits(idle_cnt_reg))'(SUSPEND_COUNT - 1)) begin
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
    end
  end

  // wake comes from the idle to non-idle edge, suspended or not
  logic line_idle_d_reg;
  always_ff @(posedge clk) begin
    line_idle_d_reg <= srst ? 1'b0 : line_idle;
  end

  logic activity;
  assign activity = (state_reg == DEV_RUN) && !line_idle && line_idle_d_reg;
  always_ff @(posedge clk) begin
    if (srst || dev_reset) begin
      suspend_flag <= 1'b0;
      wake_flag    <= 1'b0;
    end else if (suspend_flag_hit) begin
      suspend_flag <= 1'b1;
      wake_flag    <= 1'b0;
    end else if (activity) begin
      wake_flag    <= 1'b1;
      suspend_flag <= 1'b0;
    end else begin
      if (flag_clr_suspend_flag) suspend_flag <= 1'b0;
      if (flag_clr_wake) wake_flag    <= 1'b0;
    end
  end

  // pad control
  logic pad_active;
  assign pad_active = (state_reg == DEV_RUN) && !suspend_flag;
  always_ff @(posedge clk) begin
    if (srst) begin
      pad_rx_enable       <= 1'b0;
      pad_pulldown_enable <= 1'b1;
      device_active       <= 1'b0;
      pullup_dp           <= 1'b0;
      pullup_dm           <= 1'b0;
    end else begin
      pad_rx_enable       <= pad_active;
      pad_pulldown_enable <= !pad_active;
      device_active       <= (state_reg == DEV_RUN);
      pullup_dp <= (state_reg == DEV_RUN) && !low_speed_sel;
      pullup_dm <= (state_reg == DEV_RUN) && low_speed_sel;
    end
  end

  // address setup and filter
  always_ff @(posedge clk) begin
    if (srst || dev_reset || line_bus_reset) begin
      device_address_field <= DEFAULT_ADDR;
      address_enable       <= 1'b0;
    end else if (addr_wr) begin
      device_address_field <= addr_wdata;
      address_enable       <= addr_en_wdata;
    end
  end

  logic [ADDR_W-1:0] live_addr;
  assign live_addr = address_enable ? device_address_field : DEFAULT_ADDR;
  always_ff @(posedge clk) begin
    if (srst) begin
      token_accept <= 1'b0;
    end else begin
      token_accept <= token_valid && (token_addr == live_addr) && (state_reg == DEV_RUN) &&
                      ep_active[token_ep];
    end
  end

  // endpoint configuration and allocation
  logic [SIZE_W-1:0] size_reg  [NUM_EP];
  logic [BANK_W-1:0] banks_reg [NUM_EP];
  logic [NUM_EP-1:0] allocate_bit_reg;
  logic [NUM_EP-1:0] ep_en_reg;
  logic              cfg_fits;
  logic [BUF_W-1:0]  max_bytes;
  logic [BANK_W-1:0] max_banks;
  always_comb begin
    max_bytes = (ep_cfg_idx == '0) ? EP0_MAX_BYTES : EPN_MAX_BYTES;
    max_banks = (ep_cfg_idx == '0) ? EP0_MAX_BANKS : EPN_MAX_BANKS;
    // overlap between windows is deliberately not checked
    cfg_fits  = (ep_bytes(ep_size_code) <= max_bytes) && (ep_bank_count != '0) &&
                (ep_bank_count <= max_banks) &&
                (window_bytes(ep_size_code, ep_bank_count) <= RAM_BYTES);
  end

  always_ff @(posedge clk) begin
    if (srst || dev_reset) begin
      allocate_bit_reg      <= '0;
      config_ok_flag <= '0;
      for (int i = 0; i < NUM_EP; i++) begin
        size_reg[i]  <= '0;
        banks_reg[i] <= '0;
      end
    end else if (ep_cfg_wr) begin
      size_reg[ep_cfg_idx]       <= ep_size_code;
      banks_reg[ep_cfg_idx]      <= ep_bank_count;
      allocate_bit_reg[ep_cfg_idx]      <= ep_allocate_bit;
      config_ok_flag[ep_cfg_idx] <= ep_allocate_bit && cfg_fits;
    end
  end

  // window base of each endpoint: sum of lower allocated and enabled windows only
  logic [BUF_W-1:0] base_calc;
  logic             tbl_wr_reg;
  logic [EP_IDX_W-1:0] tbl_idx_reg;
  always_comb begin
    base_calc = '0;
    for (int i = 0; i < NUM_EP; i++) begin
      if (i < int'(tbl_idx_reg) && allocate_bit_reg[i] && ep_en_reg[i]) begin
        base_calc = BUF_W'(base_calc + window_bytes(size_reg[i], banks_reg[i]));
      end
    end
  end

  // table rewritten round robin; buffer contents themselves never touched
  always_ff @(posedge clk) begin
    if (srst) begin
      tbl_idx_reg <= '0;
      tbl_wr_reg  <= 1'b0;
    end else begin
      tbl_idx_reg <= tbl_idx_reg + 1'b1;
      tbl_wr_reg  <= 1'b1;
    end
  end

  logic [31:0] win_rd;
  ep_window_table #(.DEPTH(NUM_EP), .AW(EP_IDX_W), .DW(32)) u_win (
    .clk     (clk),
    .wr_en   (tbl_wr_reg),
    .wr_addr (tbl_idx_reg),
    .wr_data ({16'h0000, base_calc}),
    .rd_addr (token_ep),
    .rd_data (win_rd)
  );
  always_ff @(posedge clk) begin
    ep_win_base <= srst ? '0 : win_rd[BUF_W-1:0];
  end

  // endpoint enable, activity and data toggle
  always_ff @(posedge clk) begin
    if (srst || dev_reset) begin
      ep_en_reg             <= '0;
      ep_active             <= '0;
      toggle_sequence_field <= '0;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (line_bus_reset && i != 0) begin
          ep_en_reg[i] <= 1'b0;
        end else begin
          ep_en_reg[i] <= endpoint_enable_bit[i];
        end
        ep_active[i] <= ep_en_reg[i] && config_ok_flag[i] && !endpoint_reset_bit[i] &&
                        !(line_bus_reset && i == 0);
        if (!ep_en_reg[i] || toggle_reset_set_bit[i] || (line_bus_reset && i == 0)) begin
          toggle_sequence_field[i] <= 1'b0;
        end else if (ep_toggle_flip[i] && ep_active[i]) begin
          toggle_sequence_field[i] <= ~toggle_sequence_field[i]; // held reset keeps toggle
        end
      end
    end
  end

  // assertions
  AST_SUSPEND_FLAG_CLEARS_WAKE: assert property (@(posedge clk) disable iff (srst)
    suspend_flag_hit |=> suspend_flag && !wake_flag) else $error("suspend did not clear wake");
  AST_PAD_IDLE_DETACH: assert property (@(posedge clk) disable iff (srst)
    detach_reg |-> ##2 !pad_rx_enable || !detach_reg) else $error("pad active while detached");
  AST_PULLDOWN_IDLE: assert property (@(posedge clk) disable iff (srst)
    pad_pulldown_enable == !pad_rx_enable) else $error("pull-down and receiver disagree");
  AST_VBUS_FLAG: assert property (@(posedge clk) disable iff (srst)
    $changed(bus_voltage_status) |-> bus_voltage_change_flag) else $error("vbus change without flag");
  AST_ID_FLAG: assert property (@(posedge clk) disable iff (srst)
    $changed(role_id_status) |-> role_pin_change_flag) else $error("id change without flag");
  AST_DEV_VBUS: assert property (@(posedge clk) disable iff (srst)
    role_id_status && $stable(role_id_status) |=> bus_voltage_status == $past(sess_ok_reg))
    else $error("device vbus not following session valid");
  AST_ADDR_CLR: assert property (@(posedge clk) disable iff (srst)
    line_bus_reset |=> device_address_field == DEFAULT_ADDR && !address_enable)
    else $error("address not cleared by bus reset");
  AST_EP_DISABLED: assert property (@(posedge clk) disable iff (srst)
    !ep_en_reg[1] |=> !ep_active[1] && !toggle_sequence_field[1]) else $error("disabled endpoint active");
  AST_PULLUP_GATED: assert property (@(posedge clk) disable iff (srst)
    (pullup_dp || pullup_dm) |-> $past(state_reg == DEV_RUN)) else $error("pull-up while detached");
  AST_TOGGLE_RESET: assert property (@(posedge clk) disable iff (srst)
    toggle_reset_set_bit[2] |=> !toggle_sequence_field[2]) else $error("toggle reset ignored");
endmodule

// File: verification/usb_host_model.sv
// host stand-in that drives bus line events into the device core
`timescale 1ns/10ps
module usb_host_model (
  // clock
  input  wire logic       clk,
  // bus events
  output logic            line_idle,
  output logic            line_bus_reset,
  output logic            host_hs_capable,
  output logic            token_valid,
  output logic [6:0]      token_addr,
  output logic [2:0]      token_ep
);
  initial begin
    {line_idle, line_bus_reset, host_hs_capable, token_valid, token_addr, token_ep} = '0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_idle(input logic v);
    line_idle = v;
  endtask
  // reset is held well past sync delay so the end is unambiguous
  task automatic bus_reset(input logic hs);
    host_hs_capable = hs;
    line_bus_reset = 1'b1;
    hold(10);
    line_bus_reset = 1'b0;
    hold(4);
  endtask
  // address is scrambled outside the valid cycle, never left on the last value
  task automatic token(input logic [6:0] a, input logic [2:0] e);
    token_valid = 1'b1;
    token_addr = a;
    token_ep = e;
    hold(1);
    token_valid = 1'b0;
    token_addr = ~a;
  endtask
endmodule

// File: verification/test_usb_device_state_control.sv
// self-checking bench for the usb device state control core
`timescale 1ns/10ps
module test_usb_device_state_control;
  import usb_dev_ctrl_pkg::*;
  logic clk = 0, srst = 1, ctrl_enable = 0, detach_set = 0, detach_clr = 0, freeze_set = 0;
  logic freeze_clr = 0, role_pin_select = 1, software_role_bit = 1, flag_clr_vbus = 0, flag_clr_id = 0;
  logic flag_clr_end_of_bus_reset_flag = 0, flag_clr_suspend_flag = 0, flag_clr_wake = 0, addr_wr = 0, addr_en_wdata = 0;
  logic ep_cfg_wr = 0, ep_allocate_bit = 0, session_valid = 0, bus_level_ok = 0, role_id_pin = 1, low_speed_sel = 0;
  logic [6:0] addr_wdata = '0, device_address_field, token_addr;
  logic [2:0] ep_cfg_idx = '0, ep_size_code = '0, token_ep;
  logic [1:0] ep_bank_count = '0, speed_status;
  logic [7:0] endpoint_enable_bit = '1, endpoint_reset_bit = '0, toggle_reset_set_bit = '0, ep_toggle_flip = '0;
  logic [7:0] config_ok_flag, ep_active, toggle_sequence_field;
  logic [15:0] ep_win_base;
  logic line_idle, line_bus_reset, host_hs_capable, token_valid, token_accept, bus_voltage_status;
  logic role_id_status, bus_voltage_change_flag, role_pin_change_flag, suspend_flag, wake_flag;
  logic end_of_bus_reset_flag, usb_clock_freeze, device_active, address_enable, pad_rx_enable;
  logic pad_pulldown_enable, pullup_dp, pullup_dm;
  int error_cnt = 0, tests_run = 0, acc_cnt = 0, a, code, bk;
  usb_device_state_control #(.SUSPEND_COUNT(20)) dut_u (.*);
  usb_host_model host_u (.*);
  always #2 clk = ~clk;
  always @(posedge clk) if (token_accept === 1'b1) acc_cnt <= acc_cnt + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(2);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // behavioural count of expected accepts, compared with pulses seen
  task automatic tok(input int ad, input int e, input int acc);
    int exp_acc;
    exp_acc = acc_cnt + acc;
    host_u.token(ad[6:0], e[2:0]);
    tick(3);
    chk("token_accept", exp_acc[15:0], acc_cnt[15:0]);
  endtask
  task automatic brst(input logic hs, input logic [1:0] spd);
    pulse(flag_clr_end_of_bus_reset_flag);
    host_u.bus_reset(hs);
    chk("end_of_bus_reset_flag", 1, end_of_bus_reset_flag);
    chk("speed", spd, speed_status);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h4f55_b47a));
    tick(12);
    srst = 0;
    tick(1);
    chk("freeze", 1, usb_clock_freeze);
    chk("pulldown", 1, pad_pulldown_enable);
    chk("rx", 0, pad_rx_enable);
    chk("pullup", 0, pullup_dp);
    chk("role", 1, role_id_status);
    $display("test reset done");
    session_valid = 1;
    bus_level_ok = 1;
    ctrl_enable = 1;
    pulse(detach_clr);
    tick(8);
    chk("vbus", 1, bus_voltage_status);
    chk("vbus_flag", 1, bus_voltage_change_flag);
    chk("rx", 1, pad_rx_enable);
    chk("pullup", 1, pullup_dp);
    pulse(flag_clr_vbus);
    session_valid = 0;
    tick(8);
    chk("vbus", 0, bus_voltage_status);
    chk("vbus_flag", 1, bus_voltage_change_flag);
    session_valid = 1;
    role_id_pin = 0;
    tick(8);
    chk("role", 0, role_id_status);
    chk("id_flag", 1, role_pin_change_flag);
    chk("active", 0, device_active);
    role_pin_select = 0;
    tick(8);
    chk("role", 1, role_id_status);
    role_id_pin = 1;
    role_pin_select = 1;
    pulse(detach_clr);
    $display("test status done");
    brst(1'b1, SPEED_HIGH);
    ep_allocate_bit = 1;
    for (int i = 0; i < 12; i++) begin
      code = $urandom_range(7);
      bk = $urandom_range(3, 1);
      ep_size_code = code[2:0];
      ep_bank_count = bk[1:0];
      pulse(ep_cfg_wr);
      chk("cfg_ok", ((8 << code) <= EP0_MAX_BYTES) && (bk <= EP0_MAX_BANKS), config_ok_flag[0]);
    end
    ep_size_code = 3'h3;
    ep_bank_count = 2'h1;
    pulse(ep_cfg_wr);
    a = $urandom_range(127, 1);
    addr_wdata = a[6:0];
    pulse(addr_wr);
    chk("addr_en", 0, address_enable);
    tok(a, 0, 0);
    tok(0, 0, 1);
    addr_en_wdata = 1;
    pulse(addr_wr);
    tok(a, 0, 1);
    tok(0, 0, 0);
    tok(a, 5, 0);
    brst(1'b0, SPEED_FULL);
    chk("addr", 0, device_address_field);
    low_speed_sel = 1;
    brst(1'b1, SPEED_LOW);
    chk("pullup_dm", 1, pullup_dm);
    chk("pullup", 0, pullup_dp);
    low_speed_sel = 0;
    tick(2);
    $display("test enumerate done");
    pulse(flag_clr_wake);
    host_u.set_idle(1'b1);
    tick(12);
    chk("suspend_flag", 0, suspend_flag);
    tick(14);
    chk("suspend_flag", 1, suspend_flag);
    chk("rx", 0, pad_rx_enable);
    pulse(freeze_set);
    chk("freeze", 1, usb_clock_freeze);
    host_u.set_idle(1'b0);
    tick(6);
    chk("wake", 1, wake_flag);
    chk("suspend_flag", 0, suspend_flag);
    chk("rx", 1, pad_rx_enable);
    pulse(freeze_clr);
    chk("freeze", 0, usb_clock_freeze);
    $display("test suspend done");
    ep_toggle_flip = 8'h01;
    tick(1);
    ep_toggle_flip = '0;
    tick(2);
    chk("toggle", 1, toggle_sequence_field[0]);
    endpoint_reset_bit = 8'h01;
    tick(2);
    chk("ep_rst_active", 0, ep_active[0]);
    chk("ep_rst_cfg", 1, config_ok_flag[0]);
    chk("ep_rst_toggle", 1, toggle_sequence_field[0]);
    endpoint_reset_bit = '0;
    tick(2);
    chk("ep_active", 1, ep_active[0]);
    toggle_reset_set_bit = 8'h05;
    tick(1);
    toggle_reset_set_bit = '0;
    tick(2);
    chk("toggle", 0, toggle_sequence_field[0]);
    ep_cfg_idx = 3'h1;
    code = $urandom_range(7);
    ep_size_code = code[2:0];
    ep_bank_count = 2'h2;
    pulse(ep_cfg_wr);
    chk("cfg_ok1", ((8 << code) <= EPN_MAX_BYTES) && (2 * (8 << code) <= RAM_BYTES), config_ok_flag[1]);
    host_u.token(7'h00, 3'h1);
    tick(12);
    chk("win_base", 16'h0040, ep_win_base);
    endpoint_enable_bit[0] = 1'b0;
    tick(12);
    chk("win_base", 16'h0000, ep_win_base);
    endpoint_enable_bit[0] = 1'b1;
    tick(12);
    chk("win_base", 16'h0040, ep_win_base);
    pulse(detach_set);
    tick(2);
    chk("rx", 0, pad_rx_enable);
    chk("pullup", 0, pullup_dp);
    $display("test detach done");
    tally_and_finish;
  end
endmodule
